// [hdl/pdc_top.sv]
// divider chain and phase detector control with its register file
//
// Functional notes
// - three-bit detector reset delay select in bits 2:0, resets to 001.
// - detector up output driven while bit 5 is set, or at any time while bit 9 is set; bit 5 resets set.
// - detector down output driven while bit 6 is set, or at any time while bit 10 is set; bit 6 resets set.
// - two-bit slip threshold: 0 off, else about 5.4, 14.4, 24.1 ns; all three round up to one 40 ns clock cycle here.
// - bit 9 forces pump up output on; test only, resets clear.
// - bit 10 forces pump down output on; test only, resets clear.
// - reference divider takes the reference and divides to the comparison rate.
// - feedback ratio 16 to 525287 integer, 20 to 242283 fractional, two registers.
// - output divider supports even ratios only.
// - overall ratio is feedback over reference times output division.
// - fraction is 24 bits; integer register holds floor, fraction the remainder.
// - 14-bit correction counter; 0 and 1 disable, 2 to 16383 enable.
`timescale 1ns/100ps
`default_nettype none
module pdc_top
    import pdc_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [23:0] reg_wdata,
    input wire logic reg_wr,
    output logic [23:0] reg_rdata,
    input wire logic ref_tick,
    input wire logic vco_tick,
    output logic cmp_tick,
    output logic fb_tick,
    output logic out_clk,
    output logic detector_up,
    output logic detector_down,
    output logic slip_boost_up,
    output logic slip_boost_down,
    output logic ratio_valid
);
    typedef struct packed {
        logic [23:0] pd_ctrl;
        logic [REF_W-1:0] ref_div;
        logic [INT_W-1:0] fb_int;
        logic [FRAC_W-1:0] fb_frac;
        logic [OUT_W-1:0] out_div;
        logic [EXACT_W-1:0] exact_cnt;
        logic [FRAC_W-1:0] acc;
        logic carry;
        logic [EXACT_W-1:0] chan;
        logic up_pend;
        logic dn_pend;
        logic [3:0] rst_dly;
        logic [7:0] err_cnt;
        logic out_clk;
        logic [23:0] rdata;
    } pdc_st_t;

    pdc_st_t s_q, s_d;
    logic cmp_pulse;
    logic fb_pulse;
    logic half_pulse;
    logic [FRAC_W:0] acc_sum;
    logic [INT_W-1:0] fb_mod;
    logic [7:0] slip_thr;
    logic frac_mode;
    logic ratio_ok;
    logic [2:0] del_sel;
    logic [1:0] slip_sel;

    assign del_sel = s_q.pd_ctrl[PD_DEL_LSB +: 3];
    assign slip_sel = s_q.pd_ctrl[PD_SLIP_LSB +: 2];
    assign acc_sum = {1'b0, s_q.acc} + {1'b0, s_q.fb_frac};
    assign fb_mod = s_q.fb_int + INT_W'(s_q.carry);
    assign frac_mode = (s_q.fb_frac != '0);

    // legal feedback ratio depends on the mode
    assign ratio_ok = frac_mode ? (s_q.fb_int >= FRAC_MODE_MIN && s_q.fb_int < FRAC_MODE_MAX)
                                : (s_q.fb_int >= INT_MODE_MIN && s_q.fb_int <= INT_MODE_MAX);

    // threshold lookup, zero means feature off
    always_comb begin
        unique case (slip_sel)
            2'd1: slip_thr = SLIP_T1_CYC;
            2'd2: slip_thr = SLIP_T2_CYC;
            2'd3: slip_thr = SLIP_T3_CYC;
            default: slip_thr = 8'h00;
        endcase
    end

    // reference divider: comparison rate = reference / ref_div
    pdc_div u_ref_div (
        .core_clk(core_clk),
        .resetn(resetn),
        .tick_in(ref_tick),
        .divisor(DIV_W'(s_q.ref_div)),
        .tick_out(cmp_pulse)
    );

    // feedback divider: modulus steps to int+1 on accumulator carry
    pdc_div u_fb_div (
        .core_clk(core_clk),
        .resetn(resetn),
        .tick_in(vco_tick),
        .divisor(fb_mod),
        .tick_out(fb_pulse)
    );

    // output divider toggles every half ratio, so the ratio is always even
    pdc_div u_out_div (
        .core_clk(core_clk),
        .resetn(resetn),
        .tick_in(vco_tick),
        .divisor(DIV_W'(s_q.out_div[OUT_W-1:1])),
        .tick_out(half_pulse)
    );

    always_comb begin
        s_d = s_q;
        // register writes
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_PD_CTRL: s_d.pd_ctrl = reg_wdata;
                ADDR_REF_DIV: s_d.ref_div = reg_wdata[REF_W-1:0];
                ADDR_FB_INT: s_d.fb_int = reg_wdata[INT_W-1:0];
                ADDR_FB_FRAC: s_d.fb_frac = reg_wdata[FRAC_W-1:0];
                ADDR_OUT_DIV: s_d.out_div = {reg_wdata[OUT_W-1:1], 1'b0};
                ADDR_EXACT_CNT: s_d.exact_cnt = reg_wdata[EXACT_W-1:0];
                default: ;
            endcase
        end
        // read data registered one cycle after the address
        unique case (reg_addr)
            ADDR_PD_CTRL: s_d.rdata = s_q.pd_ctrl;
            ADDR_REF_DIV: s_d.rdata = 24'(s_q.ref_div);
            ADDR_FB_INT: s_d.rdata = 24'(s_q.fb_int);
            ADDR_FB_FRAC: s_d.rdata = s_q.fb_frac;
            ADDR_OUT_DIV: s_d.rdata = 24'(s_q.out_div);
            ADDR_EXACT_CNT: s_d.rdata = 24'(s_q.exact_cnt);
            ADDR_STATUS: s_d.rdata = {19'h0, s_q.carry, s_q.dn_pend, s_q.up_pend, frac_mode, ratio_ok};
            default: s_d.rdata = 24'h000000;
        endcase
        // fraction accumulator steps once per feedback period
        if (fb_pulse) begin
            s_d.acc = acc_sum[FRAC_W-1:0];
            s_d.carry = acc_sum[FRAC_W];
            // exact mode: restart the sequence every exact_cnt periods,
            // which cancels the 24-bit rounding offset
            if (s_q.exact_cnt > 14'h0001) begin
                if (s_q.chan + 14'h0001 >= s_q.exact_cnt) begin
                    s_d.chan = '0;
                    s_d.acc = '0;
                end else begin
                    s_d.chan = s_q.chan + 14'h0001;
                end
            end else begin
                s_d.chan = '0;
            end
        end
        // phase detector: set wins over the delayed clear
        if (s_q.up_pend && s_q.dn_pend) begin
            if (s_q.rst_dly >= {1'b0, del_sel}) begin
                s_d.up_pend = 1'b0;
                s_d.dn_pend = 1'b0;
                s_d.rst_dly = '0;
            end else begin
                s_d.rst_dly = s_q.rst_dly + 4'h1;
            end
        end else begin
            s_d.rst_dly = '0;
        end
        if (cmp_pulse) begin
            s_d.up_pend = 1'b1;
        end
        if (fb_pulse) begin
            s_d.dn_pend = 1'b1;
        end
        // phase error length, saturating
        if (s_q.up_pend != s_q.dn_pend) begin
            if (s_q.err_cnt != 8'hff) begin
                s_d.err_cnt = s_q.err_cnt + 8'h01;
            end
        end else begin
            s_d.err_cnt = '0;
        end
        if (half_pulse) begin
            s_d.out_clk = ~s_q.out_clk;
        end
    end

    // state register; reset clears the pending flags and counters,
    // then loads the register defaults so software need not rewrite them
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.pd_ctrl <= PD_CTRL_RST;
            s_q.ref_div <= REF_DIV_RST;
            s_q.fb_int <= FB_INT_RST;
            s_q.fb_frac <= FB_FRAC_RST;
            s_q.out_div <= OUT_DIV_RST;
            s_q.exact_cnt <= EXACT_CNT_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // detector outputs gated by enables, forced on by test bits
    assign detector_up = (s_q.up_pend && s_q.pd_ctrl[DETECTOR_UP_OUTPUT_ENABLE_BIT]) || s_q.pd_ctrl[PD_FORCE_UP_BIT];
    assign detector_down = (s_q.dn_pend && s_q.pd_ctrl[DETECTOR_DOWN_OUTPUT_ENABLE_BIT]) || s_q.pd_ctrl[PD_FORCE_DN_BIT];
    // extra current once the lone pulse outlasts the threshold
    assign slip_boost_up = (slip_thr != 8'h00) && s_q.up_pend && !s_q.dn_pend && (s_q.err_cnt >= slip_thr);
    assign slip_boost_down = (slip_thr != 8'h00) && s_q.dn_pend && !s_q.up_pend && (s_q.err_cnt >= slip_thr);
    // divider pulses and register port straight from their flip-flops
    assign cmp_tick = cmp_pulse;
    assign fb_tick = fb_pulse;
    assign out_clk = s_q.out_clk;
    assign ratio_valid = ratio_ok;
    assign reg_rdata = s_q.rdata;
endmodule // pdc_top
`default_nettype wire

// [hdl/pdc_pkg.sv]
// package: register map, reset values and timing constants for the divider and detector control
package pdc_pkg;
    // register offsets
    localparam logic [7:0] ADDR_REF_DIV = 8'h02;
    localparam logic [7:0] ADDR_FB_INT = 8'h03;
    localparam logic [7:0] ADDR_FB_FRAC = 8'h04;
    localparam logic [7:0] ADDR_PD_CTRL = 8'h0b;
    localparam logic [7:0] ADDR_EXACT_CNT = 8'h0c;
    localparam logic [7:0] ADDR_OUT_DIV = 8'h12;
    localparam logic [7:0] ADDR_STATUS = 8'h13;
    // field widths
    localparam int REF_W = 14;
    localparam int INT_W = 20;
    localparam int FRAC_W = 24;
    localparam int OUT_W = 8;
    localparam int EXACT_W = 14;
    localparam int DIV_W = 20;
    // reset values
    localparam logic [23:0] PD_CTRL_RST = 24'h0f8061;
    localparam logic [REF_W-1:0] REF_DIV_RST = 14'h0001;
    localparam logic [INT_W-1:0] FB_INT_RST = 20'h00019;
    localparam logic [FRAC_W-1:0] FB_FRAC_RST = 24'h000000;
    localparam logic [OUT_W-1:0] OUT_DIV_RST = 8'h02;
    localparam logic [EXACT_W-1:0] EXACT_CNT_RST = 14'h0000;
    // detector control field positions
    localparam int PD_DEL_LSB = 0;
    localparam int DETECTOR_UP_OUTPUT_ENABLE_BIT = 5;
    localparam int DETECTOR_DOWN_OUTPUT_ENABLE_BIT = 6;
    localparam int PD_SLIP_LSB = 7;
    localparam int PD_FORCE_UP_BIT = 9;
    localparam int PD_FORCE_DN_BIT = 10;
    // feedback ratio limits
    localparam logic [INT_W-1:0] INT_MODE_MIN = 20'd16;
    localparam logic [INT_W-1:0] INT_MODE_MAX = 20'd525287;
    localparam logic [INT_W-1:0] FRAC_MODE_MIN = 20'd20;
    localparam logic [INT_W-1:0] FRAC_MODE_MAX = 20'd242284;
    // slip prevention thresholds in picoseconds, turned into clock cycles (rounded up)
    localparam int CLK_PERIOD_PS = 40000;
    localparam int SLIP_T1_PS = 5400;
    localparam int SLIP_T2_PS = 14400;
    localparam int SLIP_T3_PS = 24100;
    localparam logic [7:0] SLIP_T1_CYC = 8'((SLIP_T1_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] SLIP_T2_CYC = 8'((SLIP_T2_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] SLIP_T3_CYC = 8'((SLIP_T3_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
endpackage

// [hdl/pdc_div.sv]
// pulse divider: one output pulse per divisor input pulses
`timescale 1ns/100ps
`default_nettype none
module pdc_div
    import pdc_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic tick_in,
    input wire logic [DIV_W-1:0] divisor,
    output logic tick_out
);
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic tick;
    } pdc_div_st_t;

    pdc_div_st_t s_q, s_d;

    // count input pulses; divisor 0 or 1 passes every pulse
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (tick_in) begin
            if (s_q.cnt + 20'd1 >= divisor) begin
                s_d.cnt = '0;
                s_d.tick = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 20'd1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick_out = s_q.tick;
endmodule // pdc_div
`default_nettype wire

// [tb/pdc_top_assertions.sv]
// checker: detector gating, force bits and register port relations of pdc_top
`timescale 1ns/100ps
`default_nettype none
module pdc_chk
    import pdc_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [23:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic [23:0] reg_rdata,
    input wire logic ref_tick,
    input wire logic cmp_tick,
    input wire logic detector_up,
    input wire logic detector_down,
    input wire logic slip_boost_up,
    input wire logic slip_boost_down
);
    logic [23:0] pd_q;
    // shadow of the detector word, taken on the same edge as the design takes a write
    always_ff @(posedge core_clk) begin
        if (!resetn) pd_q <= PD_CTRL_RST;
        else if (reg_wr && reg_addr == ADDR_PD_CTRL) pd_q <= reg_wdata;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // four quiet cycles cover the one-edge read latency plus a late write
    sequence pd_quiet; (reg_addr == ADDR_PD_CTRL && !reg_wr) [*4]; endsequence
    sequence hole_quiet; (reg_addr == 8'h7f && !reg_wr) [*4]; endsequence
    chk_up_gate: assert property (detector_up && !pd_q[9] |-> pd_q[5])
        else $error("up output without enable");
    chk_dn_gate: assert property (detector_down && !pd_q[10] |-> pd_q[6])
        else $error("down output without enable");
    chk_force_up: assert property (pd_q[9] |-> detector_up)
        else $error("up force ignored");
    chk_force_dn: assert property (pd_q[10] |-> detector_down)
        else $error("down force ignored");
    chk_slip_idle: assert property (pd_q[8:7] == 2'h0 |-> !slip_boost_up && !slip_boost_down)
        else $error("slip boost while disabled");
    chk_pd_readback: assert property (pd_quiet |-> reg_rdata == pd_q)
        else $error("detector word read back wrong");
    chk_hole_zero: assert property (hole_quiet |-> reg_rdata == 24'h000000)
        else $error("unmapped read not zero");
    chk_cmp_cause: assert property (cmp_tick |-> $past(ref_tick))
        else $error("comparison pulse without reference tick");
endmodule // pdc_chk
bind pdc_top pdc_chk i_chk (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .ref_tick(ref_tick),
    .cmp_tick(cmp_tick), .detector_up(detector_up), .detector_down(detector_down),
    .slip_boost_up(slip_boost_up), .slip_boost_down(slip_boost_down));
`default_nettype wire

// [tb/pdc_top_bench.sv]
// testbench: register access, detector gating and divider ratio of pdc_top
`timescale 1ns/100ps
`default_nettype none
module pdc_top_bench
    import pdc_pkg::*;
;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [23:0] reg_wdata = 24'h000000;
    logic reg_wr = 1'b0;
    logic ref_tick = 1'b0;
    logic vco_tick = 1'b0;
    logic [23:0] reg_rdata;
    logic cmp_tick, fb_tick, out_clk, detector_up, detector_down, ratio_valid, last_out;
    logic slip_up, slip_dn;
    int miscompares = 0;
    int total_checks = 0;
    int n_fb, n_tog, k;
    // ratio limit table: fraction, integer, expected legality
    logic [44:0] lim [8] = '{{24'h0, 20'd15, 1'b0}, {24'h0, 20'd16, 1'b1}, {24'h0, 20'd525287, 1'b1},
        {24'h0, 20'd525288, 1'b0}, {24'h1, 20'd19, 1'b0}, {24'h1, 20'd20, 1'b1},
        {24'h1, 20'd242283, 1'b1}, {24'h1, 20'd242284, 1'b0}};

    always #20 core_clk = ~core_clk;

    pdc_top i_pdc_top (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rdata(reg_rdata), .ref_tick(ref_tick), .vco_tick(vco_tick),
        .cmp_tick(cmp_tick), .fb_tick(fb_tick), .out_clk(out_clk), .detector_up(detector_up),
        .detector_down(detector_down), .slip_boost_up(slip_up), .slip_boost_down(slip_dn),
        .ratio_valid(ratio_valid));

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // read data trails the address by one edge; four keep clear of a late write
    task automatic rd(input logic [7:0] a, input logic [23:0] exp, input string what);
        @(posedge core_clk);
        reg_addr <= a;
        repeat (4) @(posedge core_clk);
        #1 chk(what, exp, reg_rdata);
    endtask
    task automatic run_reset;
        @(posedge core_clk);
        resetn <= 1'b0;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
    endtask
    task automatic complete_run;
        if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (5000) @(posedge core_clk);
        miscompares++;
        complete_run();
    end

    initial begin
        run_reset();
        rd(ADDR_PD_CTRL, PD_CTRL_RST, "pd reset");
        rd(ADDR_EXACT_CNT, 24'h000000, "exact reset");
        // up enable cleared: a pending up must stay off the output
        wr(ADDR_PD_CTRL, 24'h0f8041);
        @(posedge core_clk) ref_tick <= 1'b1;
        @(posedge core_clk) ref_tick <= 1'b0;
        #1 chk("cmp_tick", 24'h1, {23'h0, cmp_tick});
        @(posedge core_clk);
        #1 chk("up gated", 24'h0, {23'h0, detector_up});
        wr(ADDR_PD_CTRL, PD_CTRL_RST);
        #1 chk("up pending", 24'h1, {23'h0, detector_up});
        chk("down idle", 24'h0, {23'h0, detector_down});
        // status is read only: a write must leave it alone
        wr(ADDR_STATUS, 24'hffffff);
        rd(ADDR_STATUS, 24'h000005, "status");
        wr(ADDR_PD_CTRL, 24'h0f8661);
        #1 chk("up forced", 24'h1, {23'h0, detector_up});
        chk("down forced", 24'h1, {23'h0, detector_down});
        rd(ADDR_PD_CTRL, 24'h0f8661, "pd force");
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_PD_CTRL, PD_CTRL_RST | (24'(c) << PD_SLIP_LSB));
            rd(ADDR_PD_CTRL, PD_CTRL_RST | (24'(c) << PD_SLIP_LSB), "slip code");
            // the lone up pulse has lasted far beyond every threshold
            chk("slip boost up", {23'h0, (c != 0)}, {23'h0, slip_up});
            chk("slip boost down", 24'h0, {23'h0, slip_dn});
        end
        wr(ADDR_EXACT_CNT, 24'hffffff);
        rd(ADDR_EXACT_CNT, 24'h003fff, "exact width");
        wr(ADDR_FB_FRAC, 24'h4e4e4e);
        rd(ADDR_FB_FRAC, 24'h4e4e4e, "fraction");
        wr(ADDR_OUT_DIV, 24'h000005);
        rd(ADDR_OUT_DIV, 24'h000004, "odd out div");
        wr(8'h7f, 24'h123456);
        rd(8'h7f, 24'h000000, "unmapped");
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_FB_FRAC, lim[i][44:21]);
            wr(ADDR_FB_INT, {4'h0, lim[i][20:1]});
            #1 chk("ratio_valid", {23'h0, lim[i][0]}, {23'h0, ratio_valid});
        end
        // fresh reset so the dividers start from zero, then 64 oscillator ticks
        run_reset();
        wr(ADDR_REF_DIV, 24'h000001);
        wr(ADDR_FB_INT, 24'h000010);
        wr(ADDR_OUT_DIV, 24'h000004);
        wr(ADDR_EXACT_CNT, 24'h000001);
        #1 chk("ratio legal", 24'h1, {23'h0, ratio_valid});
        n_fb = 0;
        n_tog = 0;
        k = 0;
        last_out = out_clk;
        @(posedge core_clk) vco_tick <= 1'b1;
        repeat (70) begin
            @(posedge core_clk);
            if (++k == 64) vco_tick <= 1'b0;
            #1 if (fb_tick === 1'b1) n_fb++;
            if (out_clk !== last_out) n_tog++;
            last_out = out_clk;
        end
        chk("fb ticks", 24'd4, 24'(n_fb));
        chk("out toggles", 24'd32, 24'(n_tog));
        complete_run();
    end
endmodule // pdc_top_bench
`default_nettype wire
